// *** core/spt_params.svh ***
// Constants for the serial audio transmitter control block
`ifndef SPT_PARAMS_SVH
`define SPT_PARAMS_SVH
// Byte offsets on the register bus
`define SPT_OFF_CTRL 8'h00
`define SPT_OFF_SET 8'h04
`define SPT_OFF_CLR 8'h08
`define SPT_OFF_TOG 8'h0C
`define SPT_OFF_STAT 8'h10
`define SPT_OFF_DATA 8'h20
// Control register fields
`define SPT_B_RUN 0
`define SPT_B_IRQEN 1
`define SPT_B_OVF 2
`define SPT_B_UNF 3
`define SPT_B_W16 4
`define SPT_B_DRAIN 5
`define SPT_F_DLY_LO 16
`define SPT_F_DLY_HI 20
`define SPT_B_GATE 30
`define SPT_B_SRST 31
`define SPT_CTRL_RST 32'hC000_0020
`define SPT_CTRL_WMASK 32'hC01F_0033
`define SPT_SRST_KEEP 32'hC000_0000
// Status register fields, then zero values for the delay count and the sample pad
`define SPT_S_DONE 0
`define SPT_S_ACTIVE 1
`define SPT_S_EMPTY 2
`define SPT_S_FULL 3
`define SPT_DLY_ZERO 5'h00
`define SPT_PAD_ZERO 8'h00
`endif

// *** core/spt_pkg.sv ***
// Types shared by the transmitter control block
package spt_pkg;
  typedef logic [31:0] spt_word_t;
  typedef logic [23:0] spt_sample_t;
endpackage

// *** core/spt_ctrl.sv ***
// Transmitter control: register slave, sample FIFO, DMA pacing, output stage
//
// Design decisions made here: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "spt_params.svh"
module spt_ctrl
  import spt_pkg::*;
#(
  parameter int DEPTH = 8,
  parameter int AW = 3
)
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [7:0] address_i,
  input wire logic read_i,
  input wire logic write_i,
  input wire logic [31:0] writedata_i,
  input wire logic [3:0] byteenable_i,
  output logic [31:0] readdata_o,
  output logic waitrequest_o,
  output logic dma_req_o,
  input wire logic sample_ready_i,
  output logic [23:0] sample_o,
  output logic sample_valid_o,
  output logic irq_o
);

  // Sample formatting into the 24-bit field
  function automatic spt_sample_t fmt(input spt_word_t w, input logic w16);
    fmt = w16 ? {w[15:0], `SPT_PAD_ZERO} : w[31:8];
  endfunction

  // Byte enable expansion
  function automatic spt_word_t be_mask(input logic [3:0] be);
    be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

  spt_word_t ctrl_reg, ctrl_next;
  spt_word_t rdata_reg, rdata_next;
  spt_word_t ctrl_view, stat_view, m, wd;
  logic wait_reg, wait_next;
  logic unf_reg, unf_next, ovf_reg, ovf_next;
  logic done_reg, done_next;
  logic active_reg, active_next;
  logic ovalid_reg, ovalid_next;
  spt_sample_t odata_reg, odata_next;
  logic dreq_reg, dreq_next;
  logic [4:0] dcnt_reg, dcnt_next;
  logic irq_reg, irq_next;
  spt_sample_t mem [DEPTH];
  logic [AW-1:0] wptr_reg, wptr_next, rptr_reg, rptr_next;
  logic [AW:0] cnt_reg, cnt_next;
  logic acc, wr, gated, srst, run, drain, full, empty;
  logic push, pop, take, unf_ev, ovf_ev, data_wr;

  // Common decode
  always_comb
  begin
    acc = (read_i | write_i) & ~wait_reg;
    wr = acc & write_i;
    m = be_mask(byteenable_i);
    wd = writedata_i & m;
    srst = ctrl_reg[`SPT_B_SRST];
    gated = srst | ctrl_reg[`SPT_B_GATE];
    run = ctrl_reg[`SPT_B_RUN];
    drain = ctrl_reg[`SPT_B_DRAIN];
    full = (cnt_reg == (AW + 1)'(DEPTH));
    empty = (cnt_reg == '0);
    data_wr = wr & (address_i == `SPT_OFF_DATA);
    ctrl_view = (ctrl_reg & `SPT_CTRL_WMASK);
    ctrl_view[`SPT_B_UNF] = unf_reg;
    ctrl_view[`SPT_B_OVF] = ovf_reg;
    stat_view = '0;
    stat_view[`SPT_S_DONE] = done_reg;
    stat_view[`SPT_S_ACTIVE] = active_reg;
    stat_view[`SPT_S_EMPTY] = empty;
    stat_view[`SPT_S_FULL] = full;
  end

  // Bus answer: one wait cycle, then the access completes
  always_comb
  begin
    wait_next = ~((read_i | write_i) & wait_reg);
    rdata_next = rdata_reg;
    if ((read_i | write_i) & wait_reg)
    begin
      case (address_i)
        `SPT_OFF_CTRL, `SPT_OFF_SET, `SPT_OFF_CLR, `SPT_OFF_TOG: rdata_next = ctrl_view;
        `SPT_OFF_STAT: rdata_next = stat_view;
        default: rdata_next = '0; // Unmapped and data port read as zero
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      wait_reg <= 1'b1;
      rdata_reg <= '0;
    end
    else
    begin
      wait_reg <= wait_next;
      rdata_reg <= rdata_next;
    end
  end

  // Control register with set, clear and toggle aliases; DMA and CPU share it
  always_comb
  begin
    ctrl_next = ctrl_reg;
    if (wr)
    begin
      case (address_i)
        `SPT_OFF_CTRL: ctrl_next = (ctrl_reg & ~m) | wd;
        `SPT_OFF_SET: ctrl_next = ctrl_reg | wd;
        `SPT_OFF_CLR: ctrl_next = ctrl_reg & ~wd;
        `SPT_OFF_TOG: ctrl_next = ctrl_reg ^ wd;
        default: ctrl_next = ctrl_reg;
      endcase
    end
    ctrl_next = ctrl_next & `SPT_CTRL_WMASK;
    // Soft reset holds every field except GATE and SRST at its reset value
    if (srst)
    begin
      ctrl_next = (ctrl_next & `SPT_SRST_KEEP) | (`SPT_CTRL_RST & ~`SPT_SRST_KEEP);
    end
  end

  // Sticky flags: hardware set wins over a clear in the same cycle
  always_comb
  begin
    unf_next = unf_reg;
    ovf_next = ovf_reg;
    done_next = done_reg;
    if (wr & (address_i == `SPT_OFF_CLR))
    begin
      if (wd[`SPT_B_UNF])
      begin
        unf_next = 1'b0;
      end
      if (wd[`SPT_B_OVF])
      begin
        ovf_next = 1'b0;
      end
    end
    if (run | srst)
    begin
      done_next = 1'b0;
    end
    if (srst)
    begin
      unf_next = 1'b0;
      ovf_next = 1'b0;
    end
    if (unf_ev)
    begin
      unf_next = 1'b1;
    end
    if (ovf_ev)
    begin
      ovf_next = 1'b1;
    end
    if (active_reg & ~active_next & ~srst)
    begin
      done_next = 1'b1;
    end
    irq_next = ctrl_reg[`SPT_B_IRQEN] & (unf_reg | ovf_reg);
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      ctrl_reg <= `SPT_CTRL_RST;
      unf_reg <= 1'b0;
      ovf_reg <= 1'b0;
      done_reg <= 1'b0;
      irq_reg <= 1'b0;
    end
    else
    begin
      ctrl_reg <= ctrl_next;
      unf_reg <= unf_next;
      ovf_reg <= ovf_next;
      done_reg <= done_next;
      irq_reg <= irq_next;
    end
  end

  // Transmit path: FIFO, output stage and run/drain state
  always_comb
  begin
    push = data_wr & ~gated & ~full;
    ovf_ev = data_wr & ~gated & full; // Word dropped, not stalled
    take = ovalid_reg & sample_ready_i & ~gated;
    pop = ~gated & active_reg & ~empty & (~ovalid_reg | sample_ready_i);
    // Only while run is set: the empty FIFO at the end of a drain is not an underflow
    unf_ev = ~gated & run & active_reg & sample_ready_i & ~ovalid_reg & empty;
    active_next = active_reg;
    if (srst)
    begin
      active_next = 1'b0;
    end
    else if (gated)
    begin
      active_next = active_reg;
    end
    else if (run)
    begin
      active_next = 1'b1;
    end
    else if (drain & (~empty | ovalid_reg))
    begin
      active_next = active_reg;
    end
    else
    begin
      active_next = 1'b0;
    end
    ovalid_next = (pop | (ovalid_reg & ~take)) & active_next;
    odata_next = pop ? mem[rptr_reg] : odata_reg;
    wptr_next = push ? wptr_reg + 1'b1 : wptr_reg;
    rptr_next = pop ? rptr_reg + 1'b1 : rptr_reg;
    cnt_next = cnt_reg + (AW + 1)'(push) - (AW + 1)'(pop);
    if (srst)
    begin
      wptr_next = '0;
      rptr_next = '0;
      cnt_next = '0;
      ovalid_next = 1'b0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      active_reg <= 1'b0;
      ovalid_reg <= 1'b0;
      odata_reg <= '0;
      wptr_reg <= '0;
      rptr_reg <= '0;
      cnt_reg <= '0;
    end
    else
    begin
      active_reg <= active_next;
      ovalid_reg <= ovalid_next;
      odata_reg <= odata_next;
      wptr_reg <= wptr_next;
      rptr_reg <= rptr_next;
      cnt_reg <= cnt_next;
    end
  end

  // Sample storage; formatting happens on entry so the FIFO stays 24 bits wide
  always_ff @(posedge clk_i)
  begin
    if (push)
    begin
      mem[wptr_reg] <= fmt(writedata_i, ctrl_reg[`SPT_B_W16]);
    end
  end

  // DMA pacing: count the delay, then hold the request until a sample arrives
  always_comb
  begin
    dreq_next = dreq_reg;
    dcnt_next = dcnt_reg;
    if (gated | ~run)
    begin
      dreq_next = 1'b0;
      dcnt_next = ctrl_reg[`SPT_F_DLY_HI:`SPT_F_DLY_LO];
    end
    else if (dreq_reg)
    begin
      if (push)
      begin
        dreq_next = 1'b0;
        dcnt_next = ctrl_reg[`SPT_F_DLY_HI:`SPT_F_DLY_LO];
      end
    end
    else if (active_reg & ~full)
    begin
      if (dcnt_reg == `SPT_DLY_ZERO)
      begin
        dreq_next = 1'b1;
      end
      else
      begin
        dcnt_next = dcnt_reg - 1'b1;
      end
    end
    else
    begin
      dcnt_next = ctrl_reg[`SPT_F_DLY_HI:`SPT_F_DLY_LO];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      dreq_reg <= 1'b0;
      dcnt_reg <= '0;
    end
    else
    begin
      dreq_reg <= dreq_next;
      dcnt_reg <= dcnt_next;
    end
  end

  // All outputs come straight from flip-flops
  assign readdata_o = rdata_reg;
  assign waitrequest_o = wait_reg;
  assign dma_req_o = dreq_reg;
  assign sample_o = odata_reg;
  assign sample_valid_o = ovalid_reg;
  assign irq_o = irq_reg;

endmodule

// *** verif/spt_ctrl_props.sv ***
// Port checker for the transmitter control block
`timescale 1ns/1ps
module spt_ctrl_props (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [7:0] address_i,
  input wire logic read_i,
  input wire logic write_i,
  input wire logic [31:0] readdata_o,
  input wire logic waitrequest_o,
  input wire logic dma_req_o,
  input wire logic sample_ready_i,
  input wire logic [23:0] sample_o,
  input wire logic sample_valid_o,
  input wire logic irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // A write lands at this edge
  logic wr_land;
  assign wr_land = write_i & ~waitrequest_o;
  a_wait_one: assert property (
    (read_i | write_i) && waitrequest_o |=> !waitrequest_o) else $error("late answer");
  a_wait_short: assert property (
    !waitrequest_o |=> waitrequest_o) else $error("long answer");
  a_wait_idle: assert property (
    !(read_i | write_i) && waitrequest_o |=> waitrequest_o) else $error("stray answer");
  a_dma_drop: assert property (
    dma_req_o && wr_land && address_i == 8'h20 |=> !dma_req_o) else $error("request kept");
  a_dma_hold: assert property (
    dma_req_o && !wr_land && !$past(wr_land) |=> dma_req_o) else $error("request lost");
  a_out_hold: assert property (
    sample_valid_o && !sample_ready_i && !$past(wr_land) |=> sample_valid_o && $stable(sample_o))
    else $error("sample lost");
  a_read_zero: assert property (
    read_i && waitrequest_o && (address_i == 8'h20 || address_i == 8'h14) |=> readdata_o == 0)
    else $error("bad read");
  a_reset_quiet: assert property (disable iff (1'b0)
    reset_i |=> waitrequest_o && !dma_req_o && !sample_valid_o && !irq_o)
    else $error("reset leak");
  c_dma: cover property ($rose(dma_req_o));
  c_take: cover property (sample_valid_o && sample_ready_i);
  c_irq: cover property (irq_o);
endmodule
bind spt_ctrl spt_ctrl_props u_props (.clk_i(clk_i), .reset_i(reset_i), .address_i(address_i),
  .read_i(read_i), .write_i(write_i), .readdata_o(readdata_o), .waitrequest_o(waitrequest_o),
  .dma_req_o(dma_req_o), .sample_ready_i(sample_ready_i), .sample_o(sample_o),
  .sample_valid_o(sample_valid_o), .irq_o(irq_o));

// *** verif/spt_sink.sv ***
// Receiver model that takes formatted samples
`timescale 1ns/1ps
module spt_sink (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [23:0] sample_i,
  input wire logic sample_valid_i,
  input wire logic stall_i,
  output logic sample_ready_o,
  output logic [23:0] got_o,
  output logic [7:0] got_cnt_o
);
  // Stall lets the bench hold samples in the output stage
  assign sample_ready_o = ~stall_i;
  // Capture each sample taken on the handshake
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      got_o <= 24'h000000;
      got_cnt_o <= 8'h00;
    end
    else if (sample_valid_i && sample_ready_o)
    begin
      got_o <= sample_i;
      got_cnt_o <= got_cnt_o + 8'h01;
    end
  end
endmodule

// *** verif/spt_ctrl_tb_top.sv ***
// Self-checking bench for the transmitter control block
`timescale 1ns/1ps
module spt_ctrl_tb_top;
  import spt_pkg::*;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [7:0] address_i = 8'h00;
  logic read_i = 1'b0;
  logic write_i = 1'b0;
  spt_word_t writedata_i = 32'h00000000;
  spt_word_t readdata_o;
  logic waitrequest_o, dma_req_o, sample_ready_i, sample_valid_o, irq_o, stall = 1'b0;
  logic [23:0] sample_o, got;
  logic [7:0] got_cnt;
  int num_errors = 0;
  int cmp_count = 0;
  int cycles = 0;
  spt_ctrl u_spt_ctrl (.clk_i(clk_i), .reset_i(reset_i), .address_i(address_i),
    .read_i(read_i), .write_i(write_i), .writedata_i(writedata_i), .byteenable_i(4'hF),
    .readdata_o(readdata_o), .waitrequest_o(waitrequest_o), .dma_req_o(dma_req_o),
    .sample_ready_i(sample_ready_i), .sample_o(sample_o), .sample_valid_o(sample_valid_o),
    .irq_o(irq_o));
  spt_sink u_spt_sink (.clk_i(clk_i), .reset_i(reset_i), .sample_i(sample_o),
    .sample_valid_i(sample_valid_o), .stall_i(stall), .sample_ready_o(sample_ready_i),
    .got_o(got), .got_cnt_o(got_cnt));
  // 50 MHz clock
  initial
  begin
    forever #10 clk_i = ~clk_i;
  end
  task complete_run();
    if (num_errors == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Hang guard, far above the 140 or so cycles the run needs
  always @(posedge clk_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      num_errors++;
      complete_run();
    end
  end
  task chk(input spt_word_t g, input spt_word_t e);
    cmp_count++;
    if (g !== e)
    begin
      num_errors++;
      $display("wrong value at %0t: %h expected %h", $time, g, e);
    end
  endtask
  // Request held until waitrequest is seen low at an edge
  task bus(input logic [7:0] a, input logic w, input spt_word_t d, output spt_word_t q);
    address_i <= a;
    write_i <= w;
    read_i <= ~w;
    writedata_i <= d;
    do @(posedge clk_i); while (waitrequest_o !== 1'b0);
    q = readdata_o;
    write_i <= 1'b0;
    read_i <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input spt_word_t d);
    spt_word_t q;
    bus(a, 1'b1, d, q);
  endtask
  task rd(input logic [7:0] a, input spt_word_t e);
    spt_word_t q;
    bus(a, 1'b0, 32'h00000000, q);
    chk(q, e);
  endtask
  // Wait for the next sample at the receiver
  task take(input spt_word_t e);
    logic [7:0] c;
    c = got_cnt;
    repeat (20) if (got_cnt == c) @(posedge clk_i);
    chk({8'h00, got}, e);
  endtask
  task t_reset_vals();
    rd(8'h00, 32'hC000_0020);
    rd(8'h14, 32'h00000000);
    wr(8'h20, 32'h0000_0055);
    rd(8'h10, 32'h0000_0004);
    wr(8'h08, 32'hC000_0000);
    rd(8'h00, 32'h0000_0020);
  endtask
  task t_format();
    wr(8'h04, 32'h0000_0011);
    wr(8'h20, 32'h1234_ABCD);
    take(32'h00AB_CD00);
    wr(8'h08, 32'h0000_0010);
    wr(8'h20, 32'hA1B2_C3D4);
    take(32'h00A1_B2C3);
  endtask
  task t_dma();
    int n;
    int dl[3];
    dl = '{0, 3, 31};
    foreach (dl[i])
    begin
      n = 0;
      wr(8'h00, {11'h000, dl[i][4:0], 16'h0021});
      while (dma_req_o !== 1'b1) @(posedge clk_i);
      wr(8'h20, 32'h0000_0000);
      do
      begin
        @(posedge clk_i);
        n++;
      end
      while (dma_req_o !== 1'b1 && n < 40);
      chk(n, dl[i] + 2);
    end
  endtask
  task t_underflow();
    wr(8'h00, 32'h0000_0003);
    rd(8'h00, 32'h0000_000B);
    repeat (2) @(posedge clk_i);
    chk({31'h0, irq_o}, 32'h1);
    wr(8'h00, 32'h0000_0002);
    wr(8'h08, 32'h0000_0008);
    rd(8'h00, 32'h0000_0002);
    repeat (2) @(posedge clk_i);
    chk({31'h0, irq_o}, 32'h0);
  endtask
  task t_drain();
    stall <= 1'b1;
    wr(8'h00, 32'h0000_0021);
    wr(8'h20, 32'h0000_0100);
    wr(8'h20, 32'h0000_0200);
    wr(8'h00, 32'h0000_0020);
    rd(8'h10, 32'h0000_0002);
    stall <= 1'b0;
    repeat (10) @(posedge clk_i);
    rd(8'h10, 32'h0000_0005);
    rd(8'h00, 32'h0000_0020);
  endtask
  task t_gate();
    logic [7:0] c;
    c = got_cnt;
    wr(8'h04, 32'h4000_0001);
    wr(8'h20, 32'h0000_0300);
    wr(8'h08, 32'h4000_0000);
    repeat (5) @(posedge clk_i);
    chk({24'h0, got_cnt}, {24'h0, c});
    wr(8'h04, 32'h8000_0000);
    @(posedge clk_i);
    rd(8'h00, 32'h8000_0020);
    rd(8'h10, 32'h0000_0004);
  endtask
  initial
  begin
    repeat (4) @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
    t_reset_vals();
    t_format();
    t_dma();
    t_underflow();
    t_drain();
    t_gate();
    complete_run();
  end
endmodule
